// *** logic/fcf_top.sv ***
// serial-command register bank: volatile mode configuration and operation flags
`timescale 1ns/1ns
module fcf_top (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic [3:0] dq_in,
	output logic [3:0] dq_out,
	output logic [3:0] dq_oe_n_out,
	input wire logic write_in_progress_in,
	input wire logic erase_suspend_in,
	input wire logic program_suspend_in,
	input wire logic addr_4byte_in,
	input wire logic erase_fail_in,
	input wire logic program_fail_in,
	input wire logic program_accel_high_level_in,
	input wire logic zero_to_one_attempt_in,
	input wire logic supply_invalid_in,
	input wire logic protect_fail_in,
	output fcf_pkg::fcf_proto_t protocol_out,
	output logic hold_reset_en_out,
	output logic accel_en_out,
	output logic [2:0] drive_code_out
);
	import fcf_pkg::*;

	fcf_pin_if pins ();
	fcf_state_t state_reg;
	logic [2:0] in_cnt_reg;
	logic [2:0] out_cnt_reg;
	logic [7:0] rx_reg;
	logic [7:0] rx_next;
	logic [7:0] tx_reg;
	logic [7:0] tx_cur;
	logic [7:0] opcode_reg;
	logic [7:0] cfg_reg;
	logic [7:0] cfg_pending_reg;
	logic cfg_full_reg;
	logic err_erase_reg;
	logic err_prog_reg;
	logic err_supply_reg;
	logic err_protect_reg;
	logic [7:0] flags_rd;
	logic [7:0] rd_byte;
	logic [2:0] lanes;
	logic byte_done;
	logic cfg_commit;
	logic clear_flags;
	logic prog_err_event;
	fcf_proto_t proto;

	// lanes moved per serial clock edge in each protocol
	function automatic logic [2:0] lane_count(input fcf_proto_t p);
		case (p)
			PROTO_DUAL: lane_count = LANES_DUAL;
			PROTO_QUAD: lane_count = LANES_QUAD;
			default: lane_count = LANES_SINGLE;
		endcase
	endfunction

	// shift incoming lanes in below the byte collected so far
	function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [3:0] d,
		input fcf_proto_t p);
		case (p)
			PROTO_DUAL: shift_in = {sh[5:0], d[1:0]};
			PROTO_QUAD: shift_in = {sh[3:0], d[3:0]};
			default: shift_in = {sh[6:0], d[0]};
		endcase
	endfunction

	// pin synchronisers
	fcf_pin_sync u_sync (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.sclk_in(sclk_in),
		.cs_n_in(cs_n_in),
		.dq_in(dq_in),
		.pins(pins.sync_side)
	);

	// protocol from config; four-line wins when both selects are low
	always_comb begin
		if (!cfg_reg[CFG_QUAD_BIT]) begin
			proto = PROTO_QUAD;
		end else if (!cfg_reg[CFG_DUAL_BIT]) begin
			proto = PROTO_DUAL;
		end else begin
			proto = PROTO_SINGLE;
		end
	end

	assign lanes = lane_count(proto);
	assign rx_next = shift_in(rx_reg, pins.dq, proto);
	assign byte_done = ({1'b0, in_cnt_reg} + {1'b0, lanes}) == BYTE_BITS;
	assign protocol_out = proto;
	assign hold_reset_en_out = cfg_reg[CFG_HOLD_BIT];
	assign accel_en_out = ~cfg_reg[CFG_ACCEL_BIT];
	assign drive_code_out = cfg_reg[CFG_DRIVE_HI:CFG_DRIVE_LO];

	// flags image: status bits follow live conditions, error bits are sticky
	always_comb begin
		flags_rd = 8'h00;
		flags_rd[FLG_READY_BIT] = ~write_in_progress_in;
		flags_rd[FLG_ERASE_SUSP_BIT] = erase_suspend_in;
		flags_rd[FLG_ERASE_ERR_BIT] = err_erase_reg;
		flags_rd[FLG_PROG_ERR_BIT] = err_prog_reg;
		flags_rd[FLG_SUPPLY_ERR_BIT] = err_supply_reg;
		flags_rd[FLG_PROG_SUSP_BIT] = program_suspend_in;
		flags_rd[FLG_PROTECT_ERR_BIT] = err_protect_reg;
		flags_rd[FLG_ADDR4_BIT] = addr_4byte_in;
	end

	assign rd_byte = (opcode_reg == OP_READ_FLAGS) ? flags_rd : cfg_reg;
	assign tx_cur = (out_cnt_reg == 3'h0) ? rd_byte : tx_reg;

	// frame end actions: commit a complete config byte, or clear on a bare 50h
	assign cfg_commit = pins.cs_end & (state_reg == ST_WDATA) & cfg_full_reg;
	assign clear_flags = pins.cs_end & (state_reg == ST_NODATA);

	// command sequencer
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_reg <= ST_OPCODE;
			opcode_reg <= 8'h00;
		end else if (pins.cs_end || !pins.cs_active) begin
			state_reg <= ST_OPCODE;
		end else if (pins.sclk_rise && byte_done) begin
			case (state_reg)
				ST_OPCODE: begin
					opcode_reg <= rx_next;
					if (rx_next == OP_READ_FLAGS || rx_next == OP_READ_CFG) begin
						state_reg <= ST_SEND;
					end else if (rx_next == OP_WRITE_CFG) begin
						state_reg <= ST_WDATA;
					end else if (rx_next == OP_CLEAR_FLAGS) begin
						state_reg <= ST_NODATA;
					end else begin
						state_reg <= ST_IGNORE;
					end
				end
				ST_NODATA: state_reg <= ST_IGNORE;
				default: state_reg <= state_reg;
			endcase
		end else if (pins.sclk_rise && state_reg == ST_NODATA) begin
			state_reg <= ST_IGNORE; // any data bit spoils the clear command
		end
	end

	// input shifter and bit counter
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rx_reg <= 8'h00;
			in_cnt_reg <= 3'h0;
		end else if (!pins.cs_active) begin
			in_cnt_reg <= 3'h0;
		end else if (pins.sclk_rise) begin
			rx_reg <= rx_next;
			in_cnt_reg <= in_cnt_reg + lanes; // wraps at eight bits
		end
	end

	// pending config byte: first whole data byte only
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cfg_pending_reg <= CFG_RESET;
			cfg_full_reg <= 1'b0;
		end else if (!pins.cs_active) begin
			cfg_full_reg <= 1'b0;
		end else if (pins.sclk_rise && byte_done && state_reg == ST_WDATA && !cfg_full_reg) begin
			cfg_pending_reg <= rx_next;
			cfg_full_reg <= 1'b1;
		end
	end

	// config register updates only at the end of its write frame
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cfg_reg <= CFG_RESET;
		end else if (cfg_commit) begin
			cfg_reg <= cfg_pending_reg;
			cfg_reg[CFG_RSVD_BIT] <= 1'b0;
		end
	end

	// sticky error flags; a new event wins over a clear in the same cycle
	assign prog_err_event = program_fail_in | (program_accel_high_level_in & zero_to_one_attempt_in);
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			err_erase_reg <= 1'b0;
			err_prog_reg <= 1'b0;
			err_supply_reg <= 1'b0;
			err_protect_reg <= 1'b0;
		end else begin
			err_erase_reg <= erase_fail_in | (err_erase_reg & ~clear_flags);
			err_prog_reg <= prog_err_event | (err_prog_reg & ~clear_flags);
			err_supply_reg <= supply_invalid_in | (err_supply_reg & ~clear_flags);
			err_protect_reg <= protect_fail_in | (err_protect_reg & ~clear_flags);
		end
	end

	// output shifter: changes on the falling serial edge, byte repeats endlessly
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tx_reg <= 8'h00;
			out_cnt_reg <= 3'h0;
			dq_out <= 4'h0;
			dq_oe_n_out <= OE_N_OFF;
		end else if (!pins.cs_active || state_reg != ST_SEND) begin
			out_cnt_reg <= 3'h0;
			dq_oe_n_out <= OE_N_OFF;
		end else if (pins.sclk_fall) begin
			tx_reg <= tx_cur << lanes;
			out_cnt_reg <= out_cnt_reg + lanes;
			case (proto)
				PROTO_DUAL: begin
					dq_out <= {2'b00, tx_cur[7:6]};
					dq_oe_n_out <= OE_N_DUAL;
				end
				PROTO_QUAD: begin
					dq_out <= tx_cur[7:4];
					dq_oe_n_out <= OE_N_QUAD;
				end
				default: begin
					dq_out <= {2'b00, tx_cur[7], 1'b0};
					dq_oe_n_out <= OE_N_SINGLE;
				end
			endcase
		end
	end

	// protocol select and config update checks
	chk_quad_priority: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		!cfg_reg[CFG_QUAD_BIT] |-> protocol_out == PROTO_QUAD && lanes == LANES_QUAD)
		else $error("four-line not selected");
	chk_dual_select: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(cfg_reg[CFG_QUAD_BIT] && !cfg_reg[CFG_DUAL_BIT]) |-> protocol_out == PROTO_DUAL
		&& lanes == LANES_DUAL) else $error("two-line not selected");
	chk_single_default: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(cfg_reg[CFG_QUAD_BIT] && cfg_reg[CFG_DUAL_BIT]) |-> protocol_out == PROTO_SINGLE
		&& lanes == LANES_SINGLE) else $error("single-line not selected");
	chk_cfg_at_end: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		!$stable(cfg_reg) |-> $past(cfg_commit)) else $error("config changed mid frame");
	chk_proto_in_frame: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(pins.cs_active && !pins.cs_end) |=> $stable(protocol_out))
		else $error("protocol changed inside a frame");
	chk_rsvd_zero: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		cfg_commit |=> !cfg_reg[CFG_RSVD_BIT] && cfg_reg[7:6] == $past(cfg_pending_reg[7:6]))
		else $error("config write wrong");

	// flag register checks
	chk_ready_inverse: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		flags_rd[FLG_READY_BIT] != write_in_progress_in) else $error("ready flag wrong");
	chk_status_live: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		flags_rd[FLG_ERASE_SUSP_BIT] == erase_suspend_in && flags_rd[FLG_PROG_SUSP_BIT] ==
		program_suspend_in && flags_rd[FLG_ADDR4_BIT] == addr_4byte_in)
		else $error("status flag not live");
	chk_erase_err_set: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		erase_fail_in |=> err_erase_reg ##1 (err_erase_reg || $past(clear_flags)))
		else $error("erase error not raised");
	chk_prog_accel_err: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(program_accel_high_level_in && zero_to_one_attempt_in) |=> err_prog_reg)
		else $error("program error not raised");
	chk_supply_err_set: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		supply_invalid_in |=> err_supply_reg) else $error("supply error not raised");
	chk_error_sticky: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(err_protect_reg && !clear_flags) |=> err_protect_reg) else $error("error flag lost");
	chk_clear_all: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(clear_flags && !erase_fail_in && !prog_err_event && !supply_invalid_in
		&& !protect_fail_in) |=> !(err_erase_reg || err_prog_reg || err_supply_reg
		|| err_protect_reg)) else $error("clear left a flag");
	chk_clear_decode: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(pins.sclk_rise && byte_done && state_reg == ST_OPCODE && rx_next == OP_CLEAR_FLAGS
		&& pins.cs_active && !pins.cs_end) |=> state_reg == ST_NODATA)
		else $error("clear command not decoded");

	// serial output checks
	chk_oe_release: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		!pins.cs_active |=> dq_oe_n_out == OE_N_OFF) else $error("data lines not released");
	chk_single_lane: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(pins.sclk_fall && pins.cs_active && state_reg == ST_SEND && proto == PROTO_SINGLE)
		|=> dq_oe_n_out == OE_N_SINGLE) else $error("single-line output lane wrong");
endmodule

// *** pkg/fcf_pkg.sv ***
// package: command codes, register layout, reset values, protocol and state types
package fcf_pkg;
	// command codes
	localparam logic [7:0] OP_READ_FLAGS = 8'h70;
	localparam logic [7:0] OP_CLEAR_FLAGS = 8'h50;
	localparam logic [7:0] OP_READ_CFG = 8'h65;
	localparam logic [7:0] OP_WRITE_CFG = 8'h61;
	// volatile_mode_config layout
	localparam int CFG_QUAD_BIT = 7;
	localparam int CFG_DUAL_BIT = 6;
	localparam int CFG_RSVD_BIT = 5;
	localparam int CFG_HOLD_BIT = 4;
	localparam int CFG_ACCEL_BIT = 3;
	localparam int CFG_DRIVE_HI = 2;
	localparam int CFG_DRIVE_LO = 0;
	localparam logic [7:0] CFG_RESET = 8'hDF;
	// operation_flags layout
	localparam int FLG_READY_BIT = 7;
	localparam int FLG_ERASE_SUSP_BIT = 6;
	localparam int FLG_ERASE_ERR_BIT = 5;
	localparam int FLG_PROG_ERR_BIT = 4;
	localparam int FLG_SUPPLY_ERR_BIT = 3;
	localparam int FLG_PROG_SUSP_BIT = 2;
	localparam int FLG_PROTECT_ERR_BIT = 1;
	localparam int FLG_ADDR4_BIT = 0;
	// serial shifting
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [2:0] LANES_SINGLE = 3'h1;
	localparam logic [2:0] LANES_DUAL = 3'h2;
	localparam logic [2:0] LANES_QUAD = 3'h4;
	localparam logic [3:0] OE_N_OFF = 4'hF;
	localparam logic [3:0] OE_N_SINGLE = 4'hD;
	localparam logic [3:0] OE_N_DUAL = 4'hC;
	localparam logic [3:0] OE_N_QUAD = 4'h0;
	// synchroniser idle image {sclk, cs_n, dq}: clock low, deselected, lines high
	localparam logic [5:0] PIN_IDLE = 6'h1F;
	typedef enum logic [1:0] {
		PROTO_SINGLE = 2'b00,
		PROTO_DUAL = 2'b01,
		PROTO_QUAD = 2'b10
	} fcf_proto_t;
	typedef enum logic [2:0] {
		ST_OPCODE = 3'b000,
		ST_SEND = 3'b001,
		ST_WDATA = 3'b010,
		ST_NODATA = 3'b011,
		ST_IGNORE = 3'b100
	} fcf_state_t;
endpackage

// *** pkg/fcf_pin_if.sv ***
// interface: synchronised serial pin levels and edge events
`timescale 1ns/1ns
interface fcf_pin_if;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_active;
	logic cs_end;
	logic [3:0] dq;
	modport sync_side (output sclk_rise, output sclk_fall, output cs_active, output cs_end,
		output dq);
	modport core_side (input sclk_rise, input sclk_fall, input cs_active, input cs_end,
		input dq);
endinterface

// *** logic/fcf_pin_sync.sv ***
// three-stage pin synchronisers with agreement filter and edge events
`timescale 1ns/1ns
module fcf_pin_sync (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic [3:0] dq_in,
	fcf_pin_if.sync_side pins
);
	import fcf_pkg::*;
	logic [5:0] s1_reg;
	logic [5:0] s2_reg;
	logic [5:0] s3_reg;
	logic [5:0] lvl_reg;
	logic [5:0] lvl_next;
	logic [5:0] agree;

	// three flip-flop chain; first stage feeds only the second
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s1_reg <= PIN_IDLE; // clock idles low, so no false edge after reset
			s2_reg <= PIN_IDLE;
			s3_reg <= PIN_IDLE;
		end else begin
			s1_reg <= {sclk_in, cs_n_in, dq_in};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// a level is accepted once stages two and three agree
	assign agree = ~(s2_reg ^ s3_reg);
	assign lvl_next = (agree & s3_reg) | (~agree & lvl_reg);

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			lvl_reg <= PIN_IDLE;
		end else begin
			lvl_reg <= lvl_next;
		end
	end

	// edge events are one clock wide
	assign pins.sclk_rise = lvl_next[5] & ~lvl_reg[5];
	assign pins.sclk_fall = ~lvl_next[5] & lvl_reg[5];
	assign pins.cs_end = lvl_next[4] & ~lvl_reg[4];
	assign pins.cs_active = ~lvl_reg[4];
	assign pins.dq = lvl_reg[3:0];
endmodule

// *** tb/fcf_host_model.sv ***
// host model: sends command frames on the serial pins and captures answers
`timescale 1ns/1ns
module fcf_host_model (
	input wire logic clk_in,
	input wire logic [3:0] dq_in,
	output logic sclk_out,
	output logic cs_n_out,
	output logic [3:0] dq_out
);
	// idle: clock low, deselected
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		dq_out = 4'h5;
	end
	// one serial phase of six system clocks, well above the 4-clock minimum
	task automatic phase();
		repeat (6) @(posedge clk_in);
		#10;
	endtask
	// bits change while clock is low; sample at the rise
	task automatic group(input logic [3:0] v, output logic [3:0] s);
		dq_out = v;
		phase();
		sclk_out = 1'b1;
		s = dq_in;
		phase();
		sclk_out = 1'b0;
	endtask
	// opcode, nw write bytes, nr read bytes; msb first on the lanes in use
	task automatic frame(input logic [7:0] op, input logic [7:0] wd, input int nw,
		input int nr, input int lanes, output logic [7:0] rd);
		logic [15:0] sh;
		logic [3:0] s;
		int g;
		rd = 8'h00;
		sh = {op, wd};
		cs_n_out = 1'b0;
		phase();
		for (g = 0; g < (1 + nw) * 8 / lanes; g++) begin
			group(lanes == 1 ? {~dq_out[3:1], sh[15]} :
				lanes == 2 ? {~dq_out[3:2], sh[15:14]} : sh[15:12], s);
			sh = sh << lanes;
		end
		// released lines toggle so a stale value cannot pass for data
		for (g = 0; g < nr * 8 / lanes; g++) begin
			group(~dq_out, s);
			rd = lanes == 1 ? {rd[6:0], s[1]} : lanes == 2 ? {rd[5:0], s[1:0]} :
				{rd[3:0], s};
		end
	endtask
	// deselect ends the command; clear-flags is issued this way too
	task automatic end_frame();
		cs_n_out = 1'b1;
		phase();
		phase();
	endtask
endmodule

// *** tb/tb_top.sv ***
// testbench: register commands through the host model, flags and config checked
`timescale 1ns/1ns
module tb_top;
	import fcf_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic sclk, cs_n;
	logic [3:0] host_dq, dev_dq, dev_oe_n, pin_dq;
	logic wip, e_susp, p_susp, addr4, e_fail, p_fail, sup_bad, prot, acc_hi, z2o;
	fcf_proto_t proto;
	logic hold_en, accel_en;
	logic [2:0] drive;
	int error_cnt = 0;
	int tests_run = 0;
	int cycles = 0;
	int lanes = 1;
	// each line carries the device value where it drives, else the host value
	assign pin_dq = (dev_oe_n & host_dq) | (~dev_oe_n & dev_dq);
	fcf_top i_dut (.clk_in(clk), .arst_n_in(arst_n), .sclk_in(sclk), .cs_n_in(cs_n),
		.dq_in(pin_dq), .dq_out(dev_dq), .dq_oe_n_out(dev_oe_n),
		.write_in_progress_in(wip), .erase_suspend_in(e_susp),
		.program_suspend_in(p_susp), .addr_4byte_in(addr4), .erase_fail_in(e_fail),
		.program_fail_in(p_fail), .program_accel_high_level_in(acc_hi),
		.zero_to_one_attempt_in(z2o), .supply_invalid_in(sup_bad),
		.protect_fail_in(prot), .protocol_out(proto), .hold_reset_en_out(hold_en),
		.accel_en_out(accel_en), .drive_code_out(drive));
	fcf_host_model i_host (.clk_in(clk), .dq_in(pin_dq), .sclk_out(sclk),
		.cs_n_out(cs_n), .dq_out(host_dq));
	// 10 MHz clock
	always #50 clk = ~clk;
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			error_cnt++;
			test_done();
		end
	end
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d, errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic rd_reg(input logic [7:0] op, output logic [7:0] v);
		i_host.frame(op, 8'h00, 0, 1, lanes, v);
		i_host.end_frame();
	endtask
	// status levels and error events, changed just after an edge
	task automatic set_st(input logic [3:0] v);
		@(posedge clk);
		#10;
		{wip, e_susp, p_susp, addr4} = v;
	endtask
	task automatic pulse(input logic [5:0] ev);
		@(posedge clk);
		#10;
		{e_fail, p_fail, sup_bad, prot, acc_hi, z2o} = ev;
		@(posedge clk);
		#10;
		{e_fail, p_fail, sup_bad, prot, acc_hi, z2o} = 6'h00;
	endtask
	task automatic test_reset();
		logic [7:0] v;
		rd_reg(OP_READ_CFG, v);
		check("cfg reset", v, 8'hDF);
		check("proto reset", {6'h00, proto}, 8'h00);
		check("pins reset", {3'h0, hold_en, accel_en, drive}, 8'h17);
	endtask
	task automatic test_flags();
		logic [7:0] v;
		set_st(4'hD);
		rd_reg(OP_READ_FLAGS, v);
		check("flags busy", v, 8'h41);
		set_st(4'h2);
		rd_reg(OP_READ_FLAGS, v);
		check("flags psusp", v, 8'h84);
		set_st(4'h0);
	endtask
	task automatic test_errors();
		logic [5:0] ev[7] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h03, 6'h01, 6'h02};
		logic [7:0] ex[7] = '{8'hA0, 8'h90, 8'h88, 8'h82, 8'h90, 8'h80, 8'h80};
		logic [7:0] v;
		int i;
		for (i = 0; i < 7; i++) begin
			pulse(ev[i]);
			rd_reg(OP_READ_FLAGS, v);
			rd_reg(OP_READ_FLAGS, v);
			check("flags error", v, ex[i]);
			i_host.frame(OP_CLEAR_FLAGS, 8'h00, 0, 0, lanes, v);
			i_host.end_frame();
			rd_reg(OP_READ_FLAGS, v);
			check("flags clear", v, 8'h80);
		end
	endtask
	task automatic test_config();
		logic [7:0] wr[4] = '{8'h3F, 8'hA2, 8'h77, 8'hFF};
		logic [7:0] ec[4] = '{8'h1F, 8'h82, 8'h57, 8'hDF};
		logic [7:0] pr[4] = '{8'h02, 8'h01, 8'h02, 8'h00};
		logic [7:0] pn[4] = '{8'h17, 8'h0A, 8'h1F, 8'h17};
		int ln[4] = '{4, 2, 4, 1};
		logic [7:0] pv;
		logic [7:0] v;
		int i;
		pv = 8'h00;
		for (i = 0; i < 4; i++) begin
			i_host.frame(OP_WRITE_CFG, wr[i], 1, 0, lanes, v);
			check("proto held", {6'h00, proto}, pv);
			i_host.end_frame();
			check("proto new", {6'h00, proto}, pr[i]);
			check("cfg pins", {3'h0, hold_en, accel_en, drive}, pn[i]);
			lanes = ln[i];
			rd_reg(OP_READ_CFG, v);
			check("cfg read", v, ec[i]);
			rd_reg(OP_READ_FLAGS, v);
			check("flags mode", v, 8'h80);
			pv = pr[i];
		end
	endtask
	// refused commands: spoiled clear, unknown opcode, bytes after the first
	task automatic test_refuse();
		logic [7:0] v;
		pulse(6'h04);
		i_host.frame(OP_CLEAR_FLAGS, 8'hFF, 1, 0, lanes, v);
		i_host.end_frame();
		rd_reg(OP_READ_FLAGS, v);
		check("clear spoiled", v, 8'h82);
		i_host.frame(8'hA5, 8'h3F, 1, 0, lanes, v);
		i_host.end_frame();
		rd_reg(OP_READ_CFG, v);
		check("unknown op", v, 8'hDF);
		i_host.frame(OP_WRITE_CFG, 8'hD8, 2, 0, lanes, v);
		i_host.end_frame();
		check("extra byte", {6'h00, proto}, 8'h00);
		rd_reg(OP_READ_CFG, v);
		check("first byte", v, 8'hD8);
	endtask
	// main sequence
	initial begin
		{wip, e_susp, p_susp, addr4, e_fail, p_fail, sup_bad, prot, acc_hi, z2o} = 10'h000;
		repeat (10) @(posedge clk);
		#10;
		arst_n = 1'b1;
		repeat (6) @(posedge clk);
		#10;
		test_reset();
		test_flags();
		test_errors();
		test_config();
		test_refuse();
		test_done();
	end
endmodule
